// ### vip_defines.svh
// Constants for the vectored interrupt priority controller
`ifndef VIP_DEFINES_SVH
`define VIP_DEFINES_SVH

// =====================================================================
// Sizes
`define VIP_NSRC        32
`define VIP_VECW        7
`define VIP_AW          8
`define VIP_NTRAP       4
`define VIP_NEXT        3
`define VIP_NEV         2

// =====================================================================
// Register byte addresses
`define VIP_A_CTRL_A    8'h00
`define VIP_A_CTRL_B    8'h04
`define VIP_A_FLAG0     8'h08
`define VIP_A_FLAG1     8'h0c
`define VIP_A_EN0       8'h10
`define VIP_A_EN1       8'h14
`define VIP_A_PRIO0     8'h18
`define VIP_A_PRIO7     8'h34
`define VIP_A_PEND      8'h38
`define VIP_A_STAT      8'h3c
`define VIP_A_CORE      8'h40
`define VIP_A_EVS       8'h44
`define VIP_A_EVE       8'h48
`define VIP_A_EVC       8'h4c

// =====================================================================
// Field positions
`define VIP_NEST_BIT    15
`define VIP_TRAP_LSB    1
`define VIP_AIV_BIT     14
`define VIP_POL_LSB     0
`define VIP_IPL_LSB     5
`define VIP_MSB_BIT     3
`define VIP_PLVL_LSB    8
`define VIP_EV_REQ      0
`define VIP_EV_TRAP     1

// =====================================================================
// Values
`define VIP_PRIO_RST    3'h4
`define VIP_LVL_MAX     3'h7
`define VIP_PRIO_IMPL   32'hfaff_fffd
`define VIP_PRIO_SMALL  32'hf0ff_fffd
`define VIP_EXT0_SRC    0
`define VIP_EXT1_SRC    13
`define VIP_EXT2_SRC    29
`define VIP_RESP_OKAY   2'h0
`define VIP_RESP_SLVERR 2'h2

`endif

// ### vip_pkg.sv
// Types shared by the interrupt controller modules
`include "vip_defines.svh"

package vip_pkg;
	typedef logic [2:0] vip_prio_t;
	typedef vip_prio_t [`VIP_NSRC-1:0] vip_prio_arr_t;
	typedef enum logic [3:0] {
		SEL_CTRL_A, SEL_CTRL_B, SEL_FLAG, SEL_EN, SEL_PRIO, SEL_PEND,
		SEL_STAT, SEL_CORE, SEL_EVS, SEL_EVE, SEL_EVC, SEL_NONE
	} vip_sel_t;
endpackage

// ### vip_arb_if.sv
// Request and winner signals between register file and arbiter
`timescale 1ns/1ps
`include "vip_defines.svh"

interface vip_arb_if;
	logic [`VIP_NSRC-1:0]  active;
	vip_pkg::vip_prio_arr_t prio;
	logic                  valid;
	logic [`VIP_VECW-1:0]  vec;
	vip_pkg::vip_prio_t    lvl;
	modport ctl(output active, output prio, input valid, input vec, input lvl);
	modport arb(input active, input prio, output valid, output vec, output lvl);
endinterface

// ### vip_arbiter.sv
// Combinational priority resolver over all sources
`timescale 1ns/1ps
`include "vip_defines.svh"

module vip_arbiter (
	vip_arb_if.arb a
);
	// Walk downward so an equal level at a lower vector replaces the pick
	always_comb begin
		a.valid = 1'b0;
		a.vec   = '0;
		a.lvl   = '0;
		for (int i = `VIP_NSRC - 1; i >= 0; i--) begin
			if (a.active[i] && a.prio[i] != '0 && a.prio[i] >= a.lvl) begin
				a.valid = 1'b1;
				a.vec   = `VIP_VECW'(i);
				a.lvl   = a.prio[i];
			end
		end
	end
endmodule // vip_arbiter

// ### vip_intc.sv
// Vectored interrupt priority controller with AXI4-Lite registers
`timescale 1ns/1ps
`include "vip_defines.svh"

module vip_intc #(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	input  wire logic [`VIP_AW-1:0]    s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [`VIP_AW-1:0]    s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [`VIP_NSRC-1:0]  periph_evt,
	input  wire logic [`VIP_NEXT-1:0]  ext_irq_pin,
	input  wire logic [`VIP_NTRAP-1:0] trap_evt,
	input  wire logic                  trap_done,
	input  wire logic                  cpu_ack,
	output logic                       cpu_irq_req,
	output logic [`VIP_VECW-1:0]       pending_vector_number,
	output logic [3:0]                 pending_level,
	output logic [3:0]                 cpu_priority_level,
	output logic                       alternate_vector_table,
	output logic                       irq
);
	localparam logic [`VIP_NSRC-1:0] IMPL = SMALL_VARIANT ? `VIP_PRIO_SMALL : `VIP_PRIO_IMPL;

	// =================================================================
	// Helpers
	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [15:0] n,
		input logic [1:0] s);
		merge16 = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
	endfunction

	function automatic logic [31:0] wr32(input logic [31:0] o, input logic hi,
		input logic [15:0] n, input logic [1:0] s);
		wr32 = o;
		if (hi)
			wr32[31:16] = merge16(o[31:16], n, s);
		else
			wr32[15:0] = merge16(o[15:0], n, s);
	endfunction

	function automatic vip_pkg::vip_sel_t decode(input logic [`VIP_AW-1:0] a);
		if (a[1:0] != 2'h0) return vip_pkg::SEL_NONE;
		else if (a == `VIP_A_CTRL_A) return vip_pkg::SEL_CTRL_A;
		else if (a == `VIP_A_CTRL_B) return vip_pkg::SEL_CTRL_B;
		else if (a == `VIP_A_FLAG0 || a == `VIP_A_FLAG1) return vip_pkg::SEL_FLAG;
		else if (a == `VIP_A_EN0 || a == `VIP_A_EN1) return vip_pkg::SEL_EN;
		else if (a >= `VIP_A_PRIO0 && a <= `VIP_A_PRIO7) return vip_pkg::SEL_PRIO;
		else if (a == `VIP_A_PEND) return vip_pkg::SEL_PEND;
		else if (a == `VIP_A_STAT) return vip_pkg::SEL_STAT;
		else if (a == `VIP_A_CORE) return vip_pkg::SEL_CORE;
		else if (a == `VIP_A_EVS) return vip_pkg::SEL_EVS;
		else if (a == `VIP_A_EVE) return vip_pkg::SEL_EVE;
		else if (a == `VIP_A_EVC) return vip_pkg::SEL_EVC;
		else return vip_pkg::SEL_NONE;
	endfunction

	function automatic logic [2:0] prio_idx(input logic [`VIP_AW-1:0] a);
		logic [`VIP_AW-1:0] d;
		d = a - `VIP_A_PRIO0;
		return d[4:2];
	endfunction

	// =================================================================
	// State
	logic [`VIP_NSRC-1:0]  flag_reg, flag_next, en_reg, en_next, src_set, ext_set;
	vip_pkg::vip_prio_arr_t prio_reg;
	logic                  nest_reg, aiv_reg, msb_reg, irq_req_reg, req_prev_reg;
	logic [`VIP_NTRAP-1:0] trap_reg;
	logic [`VIP_NEXT-1:0]  pol_reg, s1_reg, s2_reg, s3_reg, stable_reg, ext_edge;
	logic [2:0]            ipl_reg;
	logic [`VIP_VECW-1:0]  pend_vec_reg;
	logic [3:0]            pend_lvl_reg;
	logic [`VIP_NEV-1:0]   evs_reg, eve_reg, ev_set;
	logic                  aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [`VIP_AW-1:0]    awaddr_reg, wa;
	logic [15:0]           wdata_reg, wd, rd_val;
	logic [1:0]            wstrb_reg, ws, bresp_reg, rresp_reg;
	logic [31:0]           rdata_reg;
	logic                  aw_ok, w_ok, wr_go, rd_ok;
	vip_pkg::vip_sel_t     wsel, rsel;

	vip_arb_if arb_bus ();
	vip_arbiter u_arb (.a(arb_bus.arb));

	assign arb_bus.active = flag_reg & en_reg;
	assign arb_bus.prio   = prio_reg;

	// =================================================================
	// AXI4-Lite write channel
	assign s_axi_awready = ce && !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = ce && !w_held_reg && !bvalid_reg;
	assign aw_ok = aw_held_reg || (s_axi_awvalid && s_axi_awready);
	assign w_ok  = w_held_reg || (s_axi_wvalid && s_axi_wready);
	assign wr_go = ce && aw_ok && w_ok && !bvalid_reg;
	assign wa    = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	assign wd    = w_held_reg ? wdata_reg : s_axi_wdata[15:0];
	// Upper lanes carry no register bits, so only two strobes matter
	assign ws    = w_held_reg ? wstrb_reg : s_axi_wstrb[1:0];
	assign wsel  = decode(wa);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `VIP_RESP_OKAY;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
		end else if (ce) begin
			if (wr_go) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= (wsel == vip_pkg::SEL_NONE) ? `VIP_RESP_SLVERR : `VIP_RESP_OKAY;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_reg <= 1'b1;
					awaddr_reg  <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_reg <= 1'b1;
					wdata_reg  <= s_axi_wdata[15:0];
					wstrb_reg  <= s_axi_wstrb[1:0];
				end
				if (s_axi_bready)
					bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// =================================================================
	// AXI4-Lite read channel
	assign s_axi_arready = ce && !rvalid_reg;
	assign rsel = decode(s_axi_araddr);

	always_comb begin
		rd_val = '0;
		rd_ok  = 1'b1;
		case (rsel)
			vip_pkg::SEL_CTRL_A: begin
				rd_val[`VIP_NEST_BIT] = nest_reg;
				rd_val[`VIP_TRAP_LSB +: `VIP_NTRAP] = trap_reg;
			end
			vip_pkg::SEL_CTRL_B: begin
				rd_val[`VIP_AIV_BIT] = aiv_reg;
				rd_val[`VIP_POL_LSB +: `VIP_NEXT] = pol_reg;
			end
			vip_pkg::SEL_FLAG: rd_val = s_axi_araddr[2] ? flag_reg[31:16] : flag_reg[15:0];
			vip_pkg::SEL_EN:   rd_val = s_axi_araddr[2] ? en_reg[31:16] : en_reg[15:0];
			vip_pkg::SEL_PRIO: begin
				for (int j = 0; j < 4; j++)
					rd_val[4*j +: 3] = prio_reg[{prio_idx(s_axi_araddr), 2'(j)}];
			end
			vip_pkg::SEL_PEND: begin
				rd_val[`VIP_VECW-1:0] = pend_vec_reg;
				rd_val[`VIP_PLVL_LSB +: 4] = pend_lvl_reg;
			end
			vip_pkg::SEL_STAT: rd_val[`VIP_IPL_LSB +: 3] = ipl_reg;
			vip_pkg::SEL_CORE: rd_val[`VIP_MSB_BIT] = msb_reg;
			vip_pkg::SEL_EVS:  rd_val[`VIP_NEV-1:0] = evs_reg;
			vip_pkg::SEL_EVE:  rd_val[`VIP_NEV-1:0] = eve_reg;
			vip_pkg::SEL_EVC:  rd_val = '0;
			default:           rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= `VIP_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= {16'h0000, rd_val};
				rresp_reg  <= rd_ok ? `VIP_RESP_OKAY : `VIP_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// =================================================================
	// External request pins: three stages, change once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg     <= '0;
			s2_reg     <= '0;
			s3_reg     <= '0;
			stable_reg <= '0;
		end else if (ce) begin
			s1_reg <= ext_irq_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < `VIP_NEXT; i++)
				if (s2_reg[i] == s3_reg[i])
					stable_reg[i] <= s3_reg[i];
		end
	end

	// Polarity 0 takes rising edges, 1 falling
	always_comb begin
		for (int i = 0; i < `VIP_NEXT; i++)
			ext_edge[i] = (s2_reg[i] == s3_reg[i]) && (s3_reg[i] != stable_reg[i]) &&
				(s3_reg[i] ^ pol_reg[i]);
		ext_set = '0;
		ext_set[`VIP_EXT0_SRC] = ext_edge[0];
		ext_set[`VIP_EXT1_SRC] = ext_edge[1];
		ext_set[`VIP_EXT2_SRC] = ext_edge[2];
	end

	assign src_set = periph_evt | ext_set;

	// =================================================================
	// Flags and enables; a set in the clearing cycle survives
	always_comb begin
		flag_next = flag_reg;
		en_next   = en_reg;
		if (wr_go && wsel == vip_pkg::SEL_FLAG)
			flag_next = wr32(flag_reg, wa[2], wd, ws);
		if (wr_go && wsel == vip_pkg::SEL_EN)
			en_next = wr32(en_reg, wa[2], wd, ws);
		flag_next = flag_next | src_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_reg <= '0;
			en_reg   <= '0;
		end else if (ce) begin
			flag_reg <= flag_next;
			en_reg   <= en_next;
		end
	end

	// =================================================================
	// Priority fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `VIP_NSRC; i++)
				prio_reg[i] <= IMPL[i] ? `VIP_PRIO_RST : 3'h0;
		end else if (ce && wr_go && wsel == vip_pkg::SEL_PRIO) begin
			for (int j = 0; j < 4; j++)
				if (ws[j/2] && IMPL[{prio_idx(wa), 2'(j)}])
					prio_reg[{prio_idx(wa), 2'(j)}] <= wd[4*j +: 3];
		end
	end

	// =================================================================
	// Global controls and CPU level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nest_reg <= 1'b0;
			trap_reg <= '0;
			aiv_reg  <= 1'b0;
			pol_reg  <= '0;
		end else if (ce) begin
			if (wr_go && wsel == vip_pkg::SEL_CTRL_A && ws[1])
				nest_reg <= wd[`VIP_NEST_BIT];
			if (wr_go && wsel == vip_pkg::SEL_CTRL_A && ws[0])
				trap_reg <= wd[`VIP_TRAP_LSB +: `VIP_NTRAP] | trap_evt;
			else
				trap_reg <= trap_reg | trap_evt;
			if (wr_go && wsel == vip_pkg::SEL_CTRL_B && ws[1])
				aiv_reg <= wd[`VIP_AIV_BIT];
			if (wr_go && wsel == vip_pkg::SEL_CTRL_B && ws[0])
				pol_reg <= wd[`VIP_POL_LSB +: `VIP_NEXT];
		end
	end

	// Only trap_evt and trap_done move the top level bit, so software cannot mask traps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msb_reg <= 1'b0;
			ipl_reg <= '0;
		end else if (ce) begin
			if (|trap_evt)
				msb_reg <= 1'b1;
			else if (trap_done)
				msb_reg <= 1'b0;
			if (cpu_ack)
				ipl_reg <= nest_reg ? `VIP_LVL_MAX : pend_lvl_reg[2:0];
			else if (wr_go && wsel == vip_pkg::SEL_STAT && ws[0])
				ipl_reg <= wd[`VIP_IPL_LSB +: 3];
		end
	end

	// =================================================================
	// Pending vector and request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_vec_reg <= '0;
			pend_lvl_reg <= '0;
			irq_req_reg  <= 1'b0;
		end else if (ce) begin
			if (arb_bus.valid) begin
				pend_vec_reg <= arb_bus.vec;
				pend_lvl_reg <= {1'b0, arb_bus.lvl};
			end
			irq_req_reg <= arb_bus.valid && !msb_reg && (arb_bus.lvl > ipl_reg);
		end
	end

	// =================================================================
	// Event status, enable and clear
	always_comb begin
		ev_set = '0;
		ev_set[`VIP_EV_REQ]  = irq_req_reg && !req_prev_reg;
		ev_set[`VIP_EV_TRAP] = |trap_evt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evs_reg      <= '0;
			eve_reg      <= '0;
			req_prev_reg <= 1'b0;
		end else if (ce) begin
			req_prev_reg <= irq_req_reg;
			if (wr_go && wsel == vip_pkg::SEL_EVC && ws[0])
				evs_reg <= (evs_reg & ~wd[`VIP_NEV-1:0]) | ev_set;
			else
				evs_reg <= evs_reg | ev_set;
			if (wr_go && wsel == vip_pkg::SEL_EVE && ws[0])
				eve_reg <= wd[`VIP_NEV-1:0];
		end
	end

	assign irq                    = |(evs_reg & eve_reg);
	assign cpu_irq_req            = irq_req_reg;
	assign pending_vector_number  = pend_vec_reg;
	assign pending_level          = pend_lvl_reg;
	assign cpu_priority_level     = {msb_reg, ipl_reg};
	assign alternate_vector_table = aiv_reg;

	// =================================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_win_above;
		ce && arb_bus.valid && !msb_reg && (arb_bus.lvl > ipl_reg);
	endsequence

	sequence s_wr_taken;
		wr_go;
	endsequence

	a_flag_sticky: assert property (ce |=> (flag_reg & $past(src_set)) == $past(src_set))
		else $error("flag lost its set");
	a_flag_keep: assert property (ce && !(wr_go && wsel == vip_pkg::SEL_FLAG)
		|=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
		else $error("flag cleared without write");
	a_ext_zero: assert property (ce && ext_edge[0] |=> flag_reg[`VIP_EXT0_SRC])
		else $error("external zero edge missed");
	a_win_enabled: assert property (arb_bus.valid |-> en_reg[arb_bus.vec[4:0]]
		&& flag_reg[arb_bus.vec[4:0]])
		else $error("winner not enabled");
	a_zero_off: assert property (arb_bus.valid |-> arb_bus.lvl != 3'h0
		&& prio_reg[arb_bus.vec[4:0]] == arb_bus.lvl)
		else $error("disabled source won");
	a_latch_vec: assert property (ce && arb_bus.valid |=> pend_vec_reg == $past(arb_bus.vec)
		&& pend_lvl_reg == {1'b0, $past(arb_bus.lvl)})
		else $error("pending vector not latched");
	a_msb_block: assert property (ce && msb_reg |=> !irq_req_reg)
		else $error("request while top bit set");
	a_req_raise: assert property (s_win_above |=> irq_req_reg)
		else $error("request not raised");
	a_msb_ro: assert property (wr_go && wsel == vip_pkg::SEL_CORE
		&& !(|trap_evt) && !trap_done |=> $stable(msb_reg))
		else $error("software changed top bit");
	a_ipl_write: assert property (wr_go && wsel == vip_pkg::SEL_STAT && ws[0] && !cpu_ack
		|=> ipl_reg == $past(wd[`VIP_IPL_LSB +: 3]))
		else $error("level write lost");
	a_bresp: assert property (s_wr_taken |=> s_axi_bvalid)
		else $error("no write response");

	for (genvar g = 0; g < `VIP_NSRC; g++) begin : g_unimpl
		if (!IMPL[g]) begin : g_chk
			a_unimpl_zero: assert property (prio_reg[g] == 3'h0)
				else $error("unimplemented field not zero");
		end
	end
endmodule // vip_intc

// ### vip_core_model.sv
// Core-side partner model that acknowledges interrupt requests
`timescale 1ns/1ps

module vip_core_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ack_en,
	input  wire logic [3:0] lat,
	input  wire logic       cpu_irq_req,
	output logic            cpu_ack
);
	// =========================================================
	// Acknowledge
	logic [3:0] cnt_reg;

	// Slow acks only take a request that is still standing
	always_ff @(posedge aclk) begin
		if (!aresetn || !ack_en || !cpu_irq_req || cpu_ack) begin
			cnt_reg <= 4'h0;
			cpu_ack <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
			cpu_ack <= (cnt_reg == lat);
		end
	end
endmodule // vip_core_model

// ### testbench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "vip_defines.svh"

module testbench;
	// =========================================================
	// Signals
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, evt;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [2:0]  pin;
	logic [3:0]  trap, plvl, cpl, lat;
	logic        tdone, ack, req, avt, irq, ack_en;
	logic [6:0]  vec;
	logic [15:0] rnd;
	logic [33:0] wq[$];
	logic [33:0] rq[$];
	int          errors, checked, n;

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	vip_intc #(.SMALL_VARIANT(1'b0)) u_vip_intc (
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_evt(evt),
		.ext_irq_pin(pin), .trap_evt(trap), .trap_done(tdone), .cpu_ack(ack),
		.cpu_irq_req(req), .pending_vector_number(vec), .pending_level(plvl),
		.cpu_priority_level(cpl), .alternate_vector_table(avt), .irq(irq)
	);

	vip_core_model u_vip_core_model (
		.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en), .lat(lat),
		.cpu_irq_req(req), .cpu_ack(ack)
	);

	// =========================================================
	// Checking
	task automatic give_verdict();
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmp(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp({18'h0, g}, {18'h0, e});
	endtask

	task automatic limit(input int k);
		if (k >= 64) begin
			errors++;
			give_verdict();
		end
	endtask

	always @(posedge aclk) begin
		if (bvalid && bready)
			cmp({bresp, 32'h0}, wq.pop_front());
		if (rvalid && rready)
			cmp({rresp, rdata}, rq.pop_front());
	end

	// =========================================================
	// Stimulus
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
		int k;
		logic ad, wd;
		wq.push_back({r, 32'h0});
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {16'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (ad && wd && bvalid === 1'b1)
				break;
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b0;
		limit(k);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
		int k;
		logic ad;
		rq.push_back({r, 16'h0, d});
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		ad = 1'b0;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (ad && rvalid === 1'b1)
				break;
			if (!ad && arready === 1'b1) begin
				ad = 1'b1;
				arvalid <= 1'b0;
			end
		end
		rready <= 1'b0;
		limit(k);
	endtask

	task automatic settle();
		repeat (3) @(posedge aclk);
		#1;
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, tdone, ack_en} = 7'h00;
		{awaddr, araddr, wdata, evt, pin, trap, lat} = '0;
		aresetn = 1'b0;
		errors = 0;
		checked = 0;
		rnd = 16'h004d;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`VIP_A_PRIO0, 16'h4404, 2'h0);
		rd(8'h30, 16'h4040, 2'h0);
		wr(`VIP_A_PRIO0, 16'hffff, 2'h0);
		rd(`VIP_A_PRIO0, 16'h7707, 2'h0);
		rd(8'h80, 16'h0, 2'h2);
		wr(8'h02, 16'h1, 2'h2);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			wr(`VIP_A_EN1, rnd, 2'h0);
			rd(`VIP_A_EN1, rnd, 2'h0);
		end
		wr(`VIP_A_EN1, 16'h0, 2'h0);
		@(posedge aclk);
		pin <= 3'h1;
		repeat (3) settle();
		rd(`VIP_A_FLAG0, 16'h0001, 2'h0);
		wr(`VIP_A_FLAG0, 16'h0, 2'h0);
		rd(`VIP_A_FLAG0, 16'h0, 2'h0);
		wr(`VIP_A_EN0, 16'h000c, 2'h0);
		wr(`VIP_A_PRIO0, 16'h4404, 2'h0);
		@(posedge aclk);
		evt <= 32'h0000_000c;
		@(posedge aclk);
		evt <= 32'h0;
		settle();
		rd(`VIP_A_PEND, 16'h0402, 2'h0);
		chk({15'h0, req}, 16'h1);
		chk({9'h0, vec}, 16'h2);
		chk({12'h0, plvl}, 16'h4);
		wr(`VIP_A_PRIO0, 16'h7404, 2'h0);
		settle();
		rd(`VIP_A_PEND, 16'h0703, 2'h0);
		wr(`VIP_A_PRIO0, 16'h0404, 2'h0);
		settle();
		rd(`VIP_A_PEND, 16'h0402, 2'h0);
		wr(`VIP_A_STAT, 16'h00e0, 2'h0);
		settle();
		chk({15'h0, req}, 16'h0);
		rd(`VIP_A_STAT, 16'h00e0, 2'h0);
		wr(`VIP_A_STAT, 16'h0, 2'h0);
		wr(`VIP_A_EVE, 16'h0002, 2'h0);
		@(posedge aclk);
		trap <= 4'h1;
		@(posedge aclk);
		trap <= 4'h0;
		settle();
		rd(`VIP_A_CORE, 16'h0008, 2'h0);
		chk({15'h0, req}, 16'h0);
		chk({15'h0, irq}, 16'h1);
		rd(`VIP_A_CTRL_A, 16'h0002, 2'h0);
		wr(`VIP_A_EVC, 16'h0002, 2'h0);
		settle();
		chk({15'h0, irq}, 16'h0);
		wr(`VIP_A_CORE, 16'h0, 2'h0);
		rd(`VIP_A_CORE, 16'h0008, 2'h0);
		@(posedge aclk);
		tdone <= 1'b1;
		@(posedge aclk);
		tdone <= 1'b0;
		settle();
		chk({15'h0, req}, 16'h1);
		wr(`VIP_A_PRIO0, 16'h7404, 2'h0);
		rnd = lfsr(rnd);
		lat <= rnd[3:0];
		ack_en <= 1'b1;
		for (n = 0; n < 64 && ack !== 1'b1; n++)
			@(posedge aclk);
		limit(n);
		ack_en <= 1'b0;
		settle();
		chk({12'h0, cpl}, 16'h7);
		chk({15'h0, req}, 16'h0);
		rd(`VIP_A_STAT, 16'h00e0, 2'h0);
		wr(`VIP_A_CTRL_B, 16'h4000, 2'h0);
		settle();
		chk({15'h0, avt}, 16'h1);
		give_verdict();
	end
endmodule // testbench
